// >>> verilog/vapt_pkg.sv
/*
  Constants and types for the virtual active-priority tracking block:
  system register encodings, field positions, reset values, state codes.
  Assumes a core that presents decoded system register accesses one at a time.
*/
package vapt_pkg;

  // system register access encodings
  localparam logic [1:0] OP0_SYS = 2'h3;
  localparam logic [2:0] RPR_OP1 = 3'h0;
  localparam logic [3:0] RPR_CRN = 4'hC;
  localparam logic [3:0] RPR_CRM = 4'hB;
  localparam logic [2:0] RPR_OP2 = 3'h3;
  localparam logic [2:0] CTL_OP1 = 3'h4;
  localparam logic [3:0] CTL_CRN = 4'hC;
  localparam logic [3:0] APR0_CRM = 4'h8;
  localparam logic [3:0] APR1_CRM = 4'h9;
  localparam logic [3:0] CTL_CRM = 4'hB;
  localparam logic [3:0] LR_LO_CRM = 4'hC;
  localparam logic [3:0] LR_HI_CRM = 4'hD;
  localparam logic [2:0] HCR_OP2 = 3'h0;
  localparam logic [2:0] VTR_OP2 = 3'h1;
  localparam logic [2:0] MISR_OP2 = 3'h2;
  localparam logic [2:0] EISR_OP2 = 3'h3;
  localparam logic [2:0] ELRSR_OP2 = 3'h5;
  localparam logic [2:0] VMCR_OP2 = 3'h7;

  // exception levels
  localparam logic [1:0] EL0 = 2'h0;
  localparam logic [1:0] EL1 = 2'h1;

  // priority tracking
  localparam int PRE_BITS_DEFAULT = 7;
  localparam int APR_WIDTH = 32;
  localparam int APR_COUNT = 4;
  localparam int LEVELS = APR_WIDTH * APR_COUNT;
  localparam int LR_COUNT = 16;
  localparam logic [7:0] IDLE_PRIORITY = 8'hFF;
  localparam logic [31:0] APR_RESET = 32'h0000_0000;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [63:0] LR_RESET = 64'h0000_0000_0000_0000;
  localparam int VTR_PRE_LSB = 26;

  typedef enum logic {
    VAPT_IDLE = 1'b0,
    VAPT_ANSWER = 1'b1
  } vapt_fsm_t;

endpackage

// >>> verilog/vapt_first_set.sv
/*
  Lowest-index set bit finder over a parameterised vector.
  Assumes nothing of its surroundings; purely combinational.
*/
module vapt_first_set #(
  parameter int WIDTH = 128,
  parameter int IDX_W = 7
) (
  input wire logic [WIDTH-1:0] vec_in,
  output logic found_out,
  output logic [IDX_W-1:0] index_out
);

  // scanning downward leaves the lowest index, the highest priority
  always_comb begin
    found_out = 1'b0;
    index_out = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (vec_in[i]) begin
        found_out = 1'b1;
        index_out = IDX_W'(i);
      end
    end
  end

endmodule

// >>> verilog/vapt_tracker.sv
/*
  Virtual running priority readout, group 0 active-priority registers and
  the virtualization control register index for one virtual CPU interface.
  Assumes the core offers one decoded system register access at a time,
  waits for the answer, and reports acknowledge and priority-drop events.
*/
module vapt_tracker #(
  parameter int PRE_BITS = vapt_pkg::PRE_BITS_DEFAULT
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic reset_into_64bit_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [1:0] req_el_in,
  input wire logic [1:0] req_op0_in,
  input wire logic [2:0] req_op1_in,
  input wire logic [3:0] req_crn_in,
  input wire logic [3:0] req_crm_in,
  input wire logic [2:0] req_op2_in,
  input wire logic [63:0] req_wdata_in,
  output logic req_ready_out,
  input wire logic sysreg_interface_enable_in,
  input wire logic common_register_trap_in,
  input wire logic nonsecure_state_bit_in,
  input wire logic secure_el2_enable_in,
  input wire logic irq_virtual_route_in,
  input wire logic fiq_virtual_route_in,
  input wire logic general_trap_bit_in,
  input wire logic el2_implemented_in,
  input wire logic legacy_vm_in,
  input wire logic ack_valid_in,
  input wire logic ack_group0_in,
  input wire logic [7:0] ack_priority_in,
  input wire logic drop_valid_in,
  input wire logic [127:0] group1_active_in,
  output logic resp_valid_out,
  output logic [63:0] resp_rdata_out,
  output logic resp_trap_el1_out,
  output logic resp_trap_el2_out,
  output logic resp_undefined_out,
  output logic resp_physical_out
);

  localparam int SHIFT = 8 - PRE_BITS;
  localparam int APR_IMPL = 1 << (PRE_BITS - 5);

  typedef struct packed {
    vapt_pkg::vapt_fsm_t fsm;
    logic [63:0] rdata;
    logic trap_el1;
    logic trap_el2;
    logic undef;
    logic physical;
    logic [vapt_pkg::LEVELS-1:0] apr;
    logic [31:0] hcr;
    logic [31:0] vmcr;
    logic [vapt_pkg::LR_COUNT-1:0][63:0] lr;
  } vapt_state_t;

  vapt_state_t st;
  vapt_state_t next_st;

  logic taken;
  logic hit_rpr;
  logic hit_ctl;
  logic hit_apr0;
  logic hit_apr1;
  logic hit_misc;
  logic hit_lr;
  logic apr_impl;
  logic el2_enabled;
  logic virt_route;
  logic [1:0] apr_n;
  logic [3:0] lr_n;
  logic [vapt_pkg::LEVELS-1:0] apr_eff;
  logic found;
  logic [6:0] top_idx;
  logic [6:0] ack_idx;
  logic [7:0] running_prio;
  logic [31:0] vtr_value;

  assign taken = req_valid_in && req_ready_out;
  assign req_ready_out = (st.fsm == vapt_pkg::VAPT_IDLE);
  assign hit_rpr = req_op0_in == vapt_pkg::OP0_SYS && req_op1_in == vapt_pkg::RPR_OP1
    && req_crn_in == vapt_pkg::RPR_CRN && req_crm_in == vapt_pkg::RPR_CRM
    && req_op2_in == vapt_pkg::RPR_OP2;
  assign hit_ctl = req_op0_in == vapt_pkg::OP0_SYS && req_op1_in == vapt_pkg::CTL_OP1
    && req_crn_in == vapt_pkg::CTL_CRN;
  assign hit_apr0 = hit_ctl && req_crm_in == vapt_pkg::APR0_CRM && !req_op2_in[2];
  assign hit_apr1 = hit_ctl && req_crm_in == vapt_pkg::APR1_CRM && !req_op2_in[2];
  assign hit_misc = hit_ctl && req_crm_in == vapt_pkg::CTL_CRM && (req_op2_in == vapt_pkg::HCR_OP2
    || req_op2_in == vapt_pkg::VTR_OP2 || req_op2_in == vapt_pkg::MISR_OP2
    || req_op2_in == vapt_pkg::EISR_OP2 || req_op2_in == vapt_pkg::ELRSR_OP2
    || req_op2_in == vapt_pkg::VMCR_OP2);
  assign hit_lr = hit_ctl && (req_crm_in == vapt_pkg::LR_LO_CRM || req_crm_in == vapt_pkg::LR_HI_CRM);
  assign apr_n = req_op2_in[1:0];
  assign lr_n = {req_crm_in[0], req_op2_in};
  // only registers backed by preemption bits
  assign apr_impl = 32'(apr_n) < APR_IMPL;
  // group 0 inert while EL2 is off here
  assign el2_enabled = el2_implemented_in && (nonsecure_state_bit_in || secure_el2_enable_in);
  assign apr_eff = el2_enabled ? st.apr : '0;
  assign virt_route = (irq_virtual_route_in || fiq_virtual_route_in) && !general_trap_bit_in
    && (nonsecure_state_bit_in || secure_el2_enable_in);
  assign vtr_value = 32'(PRE_BITS - 1) << vapt_pkg::VTR_PRE_LSB;
  assign ack_idx = 7'(ack_priority_in >> SHIFT);

  vapt_first_set #(
    .WIDTH(vapt_pkg::LEVELS),
    .IDX_W(7)
  ) u_first (
    .vec_in(apr_eff | group1_active_in),
    .found_out(found),
    .index_out(top_idx)
  );

  // idle value when no undropped level
  // fixed idle code, level scaled to full byte
  assign running_prio = found ? 8'({1'b0, top_idx} << SHIFT) : vapt_pkg::IDLE_PRIORITY;

  always_comb begin
    next_st = st;
    next_st.fsm = vapt_pkg::VAPT_IDLE;
    if (taken) begin
      next_st.fsm = vapt_pkg::VAPT_ANSWER;
      next_st.rdata = '0;
      next_st.trap_el1 = 1'b0;
      next_st.trap_el2 = 1'b0;
      next_st.undef = 1'b0;
      next_st.physical = 1'b0;
      if (hit_rpr) begin
        if (req_write_in || req_el_in == vapt_pkg::EL0) begin
          next_st.undef = 1'b1;
        end else if (req_el_in != vapt_pkg::EL1) begin
          next_st.physical = 1'b1;
        end else if (!sysreg_interface_enable_in) begin
          next_st.trap_el1 = 1'b1;
        end else if (common_register_trap_in
            && (nonsecure_state_bit_in || secure_el2_enable_in)) begin
          next_st.trap_el2 = 1'b1;
        end else if (virt_route) begin
          next_st.rdata = {56'h0, running_prio};
        end else begin
          next_st.physical = 1'b1;
        end
      end else if (hit_ctl && (hit_apr0 || hit_apr1 || hit_misc || hit_lr)) begin
        if (req_el_in == vapt_pkg::EL0 || req_el_in == vapt_pkg::EL1) begin
          next_st.undef = 1'b1;
        end else if (!el2_implemented_in) begin
          next_st.rdata = '0;
        end else if (hit_apr0) begin
          if (!apr_impl) begin
            next_st.undef = 1'b1;
          end else if (req_write_in) begin
            // low half stored, upper half dropped
            next_st.apr[32'(apr_n) * vapt_pkg::APR_WIDTH +: vapt_pkg::APR_WIDTH] = req_wdata_in[31:0];
          end else begin
            next_st.rdata = {32'h0,
              st.apr[32'(apr_n) * vapt_pkg::APR_WIDTH +: vapt_pkg::APR_WIDTH]};
          end
        end else if (hit_apr1) begin
          // group 1 storage lives elsewhere; only the access kind is settled here
          next_st.undef = !apr_impl;
          next_st.physical = apr_impl;
        end else if (hit_misc) begin
          // RW control words, RO status words
          if (req_op2_in == vapt_pkg::HCR_OP2) begin
            if (req_write_in) next_st.hcr = req_wdata_in[31:0];
            else next_st.rdata = {32'h0, st.hcr};
          end else if (req_op2_in == vapt_pkg::VMCR_OP2) begin
            if (req_write_in) next_st.vmcr = req_wdata_in[31:0];
            else next_st.rdata = {32'h0, st.vmcr};
          end else if (req_write_in) begin
            next_st.undef = 1'b1;
          end else if (req_op2_in == vapt_pkg::VTR_OP2) begin
            next_st.rdata = {32'h0, vtr_value};
          end
        end else begin
          if (req_write_in) next_st.lr[lr_n] = req_wdata_in;
          else next_st.rdata = st.lr[lr_n];
        end
      end else begin
        next_st.undef = 1'b1;
      end
    end
    // drop clears the top level when it is a group 0 level, acknowledge sets; set wins
    // legacy guests get no group 0 set on acknowledge; drop still clears
    if (drop_valid_in && found && apr_eff[top_idx]) begin
      next_st.apr[top_idx] = 1'b0;
    end
    if (ack_valid_in && ack_group0_in && el2_enabled && !legacy_vm_in) begin
      next_st.apr[ack_idx] = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st.fsm <= vapt_pkg::VAPT_IDLE;
      st.rdata <= '0;
      st.trap_el1 <= 1'b0;
      st.trap_el2 <= 1'b0;
      st.undef <= 1'b0;
      st.physical <= 1'b0;
      st.hcr <= vapt_pkg::CTL_RESET;
      st.vmcr <= vapt_pkg::CTL_RESET;
      st.lr <= {vapt_pkg::LR_COUNT{vapt_pkg::LR_RESET}};
      // defined clear only on wide reset entry
      if (reset_into_64bit_in) begin
        st.apr <= {vapt_pkg::APR_COUNT{vapt_pkg::APR_RESET}};
      end
    end else begin
      st <= next_st;
    end
  end

  assign resp_valid_out = (st.fsm == vapt_pkg::VAPT_ANSWER);
  assign resp_rdata_out = st.rdata;
  assign resp_trap_el1_out = st.trap_el1;
  assign resp_trap_el2_out = st.trap_el2;
  assign resp_undefined_out = st.undef;
  assign resp_physical_out = st.physical;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence rpr_el1_read_s;
    taken && hit_rpr && !req_write_in && req_el_in == vapt_pkg::EL1;
  endsequence

  sequence answer_s;
    resp_valid_out && !req_ready_out;
  endsequence

  rpr_read_only_a: assert property (
    (taken && hit_rpr && req_write_in) |=> answer_s ##0 resp_undefined_out)
    else $error("running priority write not refused");

  idle_priority_a: assert property (
    (rpr_el1_read_s and (sysreg_interface_enable_in && !common_register_trap_in
      && virt_route && !found)) |=> answer_s ##0 resp_rdata_out == 64'h0000_0000_0000_00FF)
    else $error("idle priority not returned");

  trap_el1_a: assert property (
    (rpr_el1_read_s and !sysreg_interface_enable_in)
      |=> resp_trap_el1_out && !resp_trap_el2_out ##1 req_ready_out)
    else $error("disabled interface read not trapped to EL1");

  trap_el2_ns_a: assert property (
    (rpr_el1_read_s and (sysreg_interface_enable_in && nonsecure_state_bit_in
      && common_register_trap_in)) |=> resp_trap_el2_out && resp_rdata_out == 64'h0)
    else $error("non-secure common trap missed");

  trap_el2_sec_a: assert property (
    (rpr_el1_read_s and (sysreg_interface_enable_in && !nonsecure_state_bit_in
      && secure_el2_enable_in && common_register_trap_in)) |=> resp_trap_el2_out)
    else $error("secure common trap missed");

  physical_route_a: assert property (
    (rpr_el1_read_s and (sysreg_interface_enable_in && !common_register_trap_in && !virt_route))
      |=> resp_physical_out && !resp_undefined_out)
    else $error("physical register not selected");

  apr_upper_zero_a: assert property (
    (taken && hit_apr0 && !req_write_in) |=> resp_rdata_out[63:32] == 32'h0)
    else $error("active-priority upper half not zero");

  apr_reset_a: assert property (@(posedge clk_in) disable iff (1'b0)
    (!resetn_in && reset_into_64bit_in) |=> st.apr == '0)
    else $error("active priorities not cleared by reset");

  ack_sets_a: assert property (
    (ack_valid_in && ack_group0_in && el2_enabled && !legacy_vm_in)
      |=> st.apr[$past(ack_idx)])
    else $error("acknowledge did not set its level");

  unimpl_apr_a: assert property (
    (taken && hit_apr0 && !apr_impl && el2_implemented_in && req_el_in[1])
      |=> resp_undefined_out)
    else $error("unimplemented register not undefined");

  legacy_hold_a: assert property (
    (legacy_vm_in && !drop_valid_in && !(taken && hit_apr0)) |=> $stable(st.apr))
    else $error("legacy guest changed group 0 state");

endmodule

// >>> tb/vapt_core_model.sv
/*
  Core-side model: issues one decoded system register access at a time.
  Assumes ready is combinational and the answer is registered on the taking edge.
*/
module vapt_core_model (
  input wire logic clk_in,
  input wire logic req_ready_in,
  input wire logic resp_valid_in,
  input wire logic [63:0] resp_rdata_in,
  input wire logic [3:0] resp_flags_in,
  output logic req_valid_out,
  output logic req_write_out,
  output logic [1:0] req_el_out,
  output logic [2:0] req_op1_out,
  output logic [3:0] req_crm_out,
  output logic [2:0] req_op2_out,
  output logic [63:0] req_wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen;
  logic [63:0] rd;
  logic [3:0] flags;
  initial begin
    req_valid_out = 1'b0;
    {req_write_out, req_el_out, req_op1_out, req_crm_out, req_op2_out} = '0;
    req_wdata_out = 64'h0;
  end
  // request held until the taking edge; the next one waits a further edge
  task automatic access(input logic wr, input logic [1:0] el, input logic [2:0] op1,
                        input logic [3:0] crm, input logic [2:0] op2, input logic [63:0] wd);
    int n;
    @(posedge clk_in);
    #1;
    {req_write_out, req_el_out, req_op1_out, req_crm_out, req_op2_out} = {wr, el, op1, crm, op2};
    req_wdata_out = wd;
    req_valid_out = 1'b1;
    n = 0;
    while (req_ready_in !== 1'b1 && n < 20) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    @(posedge clk_in);
    #1;
    req_valid_out = 1'b0;
    // released data flips so a stale value cannot pass for a held one
    req_wdata_out = ~req_wdata_out;
    seen = resp_valid_in;
    rd = resp_rdata_in;
    flags = resp_flags_in;
  endtask
endmodule

// >>> tb/virtual_active_priority_tracking_test.sv
/*
  Self-checking bench for the active-priority tracker with seven, six and five preemption bits.
  Assumes the core model in vapt_core_model issues every register access.
*/
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); n_fail++; end end
module virtual_active_priority_tracking_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] RPR_E = {vapt_pkg::RPR_OP1, vapt_pkg::RPR_CRM, vapt_pkg::RPR_OP2};
  localparam logic [9:0] VTR_E = {vapt_pkg::CTL_OP1, vapt_pkg::CTL_CRM, vapt_pkg::VTR_OP2};
  localparam logic [9:0] HCR_E = {vapt_pkg::CTL_OP1, vapt_pkg::CTL_CRM, vapt_pkg::HCR_OP2};
  localparam logic [9:0] G1_E = {vapt_pkg::CTL_OP1, vapt_pkg::APR1_CRM, 3'h0};
  localparam logic [9:0] LR_E = {vapt_pkg::CTL_OP1, vapt_pkg::LR_HI_CRM, 3'h7};
  // config {enable, common trap, nonsecure, secure el2, irq, fiq, general trap}, flags
  localparam logic [10:0] TAB [9] = '{{7'h54, 4'h0}, {7'h14, 4'h8}, {7'h74, 4'h4},
    {7'h6C, 4'h4}, {7'h44, 4'h1}, {7'h55, 4'h1}, {7'h50, 4'h1}, {7'h52, 4'h0}, {7'h4C, 4'h0}};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wide = 1'b1;
  logic [6:0] cfg = 7'h54;
  logic el2_impl = 1'b1;
  logic legacy = 1'b0;
  logic ack = 1'b0;
  logic ack_g0 = 1'b1;
  logic [63:0] rd5, rd6;
  logic [3:0] f5, f6;
  logic [7:0] ack_prio = 8'h00;
  logic drop = 1'b0;
  logic [127:0] group1 = '0;
  logic ready, valid, write, resp_valid, t1, t2, undef, phys;
  logic [1:0] el;
  logic [2:0] op1, op2;
  logic [3:0] crm;
  logic [63:0] wdata, rdata;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  vapt_core_model core (.clk_in(clk), .req_ready_in(ready), .resp_valid_in(resp_valid),
    .resp_rdata_in(rdata), .resp_flags_in({t1, t2, undef, phys}), .req_valid_out(valid),
    .req_write_out(write), .req_el_out(el), .req_op1_out(op1), .req_crm_out(crm),
    .req_op2_out(op2), .req_wdata_out(wdata));
  vapt_tracker #(.PRE_BITS(7)) DUT (.clk_in(clk), .resetn_in(resetn),
    .reset_into_64bit_in(wide), .req_valid_in(valid), .req_write_in(write), .req_el_in(el),
    .req_op0_in(vapt_pkg::OP0_SYS), .req_op1_in(op1), .req_crn_in(vapt_pkg::CTL_CRN),
    .req_crm_in(crm), .req_op2_in(op2), .req_wdata_in(wdata), .req_ready_out(ready),
    .sysreg_interface_enable_in(cfg[6]), .common_register_trap_in(cfg[5]),
    .nonsecure_state_bit_in(cfg[4]), .secure_el2_enable_in(cfg[3]),
    .irq_virtual_route_in(cfg[2]), .fiq_virtual_route_in(cfg[1]),
    .general_trap_bit_in(cfg[0]), .el2_implemented_in(el2_impl), .legacy_vm_in(legacy),
    .ack_valid_in(ack), .ack_group0_in(ack_g0), .ack_priority_in(ack_prio),
    .drop_valid_in(drop), .group1_active_in(group1), .resp_valid_out(resp_valid),
    .resp_rdata_out(rdata), .resp_trap_el1_out(t1), .resp_trap_el2_out(t2),
    .resp_undefined_out(undef), .resp_physical_out(phys));
  // narrower interfaces see the same traffic; their answers are read beside the main one
  vapt_tracker #(.PRE_BITS(6)) DUT6 (.clk_in(clk), .resetn_in(resetn),
    .reset_into_64bit_in(wide), .req_valid_in(valid), .req_write_in(write), .req_el_in(el),
    .req_op0_in(vapt_pkg::OP0_SYS), .req_op1_in(op1), .req_crn_in(vapt_pkg::CTL_CRN),
    .req_crm_in(crm), .req_op2_in(op2), .req_wdata_in(wdata), .req_ready_out(),
    .sysreg_interface_enable_in(cfg[6]), .common_register_trap_in(cfg[5]),
    .nonsecure_state_bit_in(cfg[4]), .secure_el2_enable_in(cfg[3]),
    .irq_virtual_route_in(cfg[2]), .fiq_virtual_route_in(cfg[1]),
    .general_trap_bit_in(cfg[0]), .el2_implemented_in(el2_impl), .legacy_vm_in(legacy),
    .ack_valid_in(ack), .ack_group0_in(ack_g0), .ack_priority_in(ack_prio),
    .drop_valid_in(drop), .group1_active_in(group1), .resp_valid_out(),
    .resp_rdata_out(rd6), .resp_trap_el1_out(f6[3]), .resp_trap_el2_out(f6[2]),
    .resp_undefined_out(f6[1]), .resp_physical_out(f6[0]));
  vapt_tracker #(.PRE_BITS(5)) DUT5 (.clk_in(clk), .resetn_in(resetn),
    .reset_into_64bit_in(wide), .req_valid_in(valid), .req_write_in(write), .req_el_in(el),
    .req_op0_in(vapt_pkg::OP0_SYS), .req_op1_in(op1), .req_crn_in(vapt_pkg::CTL_CRN),
    .req_crm_in(crm), .req_op2_in(op2), .req_wdata_in(wdata), .req_ready_out(),
    .sysreg_interface_enable_in(cfg[6]), .common_register_trap_in(cfg[5]),
    .nonsecure_state_bit_in(cfg[4]), .secure_el2_enable_in(cfg[3]),
    .irq_virtual_route_in(cfg[2]), .fiq_virtual_route_in(cfg[1]),
    .general_trap_bit_in(cfg[0]), .el2_implemented_in(el2_impl), .legacy_vm_in(legacy),
    .ack_valid_in(ack), .ack_group0_in(ack_g0), .ack_priority_in(ack_prio),
    .drop_valid_in(drop), .group1_active_in(group1), .resp_valid_out(),
    .resp_rdata_out(rd5), .resp_trap_el1_out(f5[3]), .resp_trap_el2_out(f5[2]),
    .resp_undefined_out(f5[1]), .resp_physical_out(f5[0]));
  function automatic logic [9:0] apr(input int n);
    return {vapt_pkg::CTL_OP1, vapt_pkg::APR0_CRM, 3'(n)};
  endfunction
  task automatic go(input int wr, input logic [1:0] e, input logic [9:0] enc,
                    input logic [63:0] wd, input logic [63:0] ed, input logic [3:0] ef,
                    input string nm);
    core.access(wr[0], e, enc[9:7], enc[6:3], enc[2:0], wd);
    `CHK({nm, " answer"}, 1'b1, core.seen)
    `CHK({nm, " data"}, ed, core.rd)
    `CHK({nm, " flags"}, ef, core.flags)
  endtask
  task automatic ev(input logic a, input logic [7:0] p, input logic d);
    @(posedge clk);
    #1;
    ack = a;
    ack_prio = p;
    drop = d;
    @(posedge clk);
    #1;
    ack = 1'b0;
    drop = 1'b0;
  endtask
  task automatic do_reset(input int n);
    @(posedge clk);
    #1;
    resetn = 1'b0;
    repeat (n) @(posedge clk);
    #1;
    resetn = 1'b1;
  endtask
  task automatic t_reset;
    for (int n = 0; n < 4; n++) go(0, 2'h2, apr(n), 64'h0, 64'h0, 4'h0, "apr reset");
    go(0, 2'h1, RPR_E, 64'h0, 64'hFF, 4'h0, "rpr idle");
    go(0, 2'h2, VTR_E, 64'h0, 64'h6 << vapt_pkg::VTR_PRE_LSB, 4'h0, "type reg");
  endtask
  task automatic t_narrow;
    ev(1'b1, 8'hCB, 1'b0);
    go(0, 2'h2, apr(0), 64'h0, 64'h0, 4'h0, "apr0 seven");
    `CHK("apr0 six", 64'h0, rd6)
    `CHK("apr0 five", 64'h0200_0000, rd5)
    go(0, 2'h2, apr(1), 64'h0, 64'h0, 4'h0, "apr1 seven");
    `CHK("apr1 six", 64'h0004_0000, rd6)
    `CHK("apr1 five", 4'h2, f5)
    go(0, 2'h2, apr(3), 64'h0, 64'h20, 4'h0, "apr3 seven");
    `CHK("apr3 six", 4'h2, f6)
    go(0, 2'h1, RPR_E, 64'h0, 64'hCA, 4'h0, "rpr seven");
    `CHK("rpr six", 64'hC8, rd6)
    `CHK("rpr five", 64'hC8, rd5)
    go(0, 2'h2, VTR_E, 64'h0, 64'h6 << vapt_pkg::VTR_PRE_LSB, 4'h0, "type seven");
    `CHK("type six", 64'h5 << vapt_pkg::VTR_PRE_LSB, rd6)
    `CHK("type five", 64'h4 << vapt_pkg::VTR_PRE_LSB, rd5)
    ev(1'b0, 8'h00, 1'b1);
    go(0, 2'h1, RPR_E, 64'h0, 64'hFF, 4'h0, "rpr seven idle");
    `CHK("rpr six idle", 64'hFF, rd6)
    `CHK("rpr five idle", 64'hFF, rd5)
  endtask
  task automatic t_group1;
    group1 = 128'h400;
    ack_g0 = 1'b0;
    ev(1'b1, 8'h30, 1'b0);
    go(0, 2'h2, apr(0), 64'h0, 64'h0, 4'h0, "group1 ack");
    ack_g0 = 1'b1;
    ev(1'b1, 8'h40, 1'b0);
    go(0, 2'h1, RPR_E, 64'h0, 64'h14, 4'h0, "rpr group1");
    ev(1'b0, 8'h00, 1'b1);
    go(0, 2'h2, apr(1), 64'h0, 64'h1, 4'h0, "drop spares group0");
    group1 = '0;
    go(0, 2'h1, RPR_E, 64'h0, 64'h40, 4'h0, "rpr group0");
    ev(1'b0, 8'h00, 1'b1);
    go(0, 2'h1, RPR_E, 64'h0, 64'hFF, 4'h0, "rpr group0 dropped");
  endtask
  task automatic t_track;
    ev(1'b1, 8'h42, 1'b0);
    go(0, 2'h2, apr(1), 64'h0, 64'h2, 4'h0, "apr1 level");
    go(0, 2'h1, RPR_E, 64'h0, 64'h42, 4'h0, "rpr active");
    ev(1'b1, 8'hC5, 1'b0);
    go(0, 2'h2, apr(3), 64'h0, 64'h4, 4'h0, "apr3 level");
    ev(1'b0, 8'h00, 1'b1);
    go(0, 2'h1, RPR_E, 64'h0, 64'hC4, 4'h0, "rpr after drop");
    ev(1'b0, 8'h00, 1'b1);
    go(0, 2'h1, RPR_E, 64'h0, 64'hFF, 4'h0, "rpr all dropped");
    go(0, 2'h2, apr(3), 64'h0, 64'h0, 4'h0, "apr3 dropped");
  endtask
  task automatic t_write;
    go(1, 2'h2, apr(2), 64'hFFFF_FFFF_A5A5_5A5A, 64'h0, 4'h0, "apr2 write");
    go(0, 2'h2, apr(2), 64'h0, 64'hA5A5_5A5A, 4'h0, "apr2 upper zero");
    go(1, 2'h2, apr(2), 64'h0, 64'h0, 4'h0, "apr2 clear");
    go(1, 2'h1, RPR_E, 64'h1, 64'h0, 4'h2, "rpr write");
    go(0, 2'h1, {3'h0, 4'hB, 3'h2}, 64'h0, 64'h0, 4'h2, "bad encoding");
    go(1, 2'h2, LR_E, 64'h1234_5678_9ABC_DEF0, 64'h0, 4'h0, "lr write");
    go(0, 2'h2, LR_E, 64'h0, 64'h1234_5678_9ABC_DEF0, 4'h0, "lr read");
    go(1, 2'h2, VTR_E, 64'h1, 64'h0, 4'h2, "type write");
    go(1, 2'h2, HCR_E, 64'h1234, 64'h0, 4'h0, "hcr write");
    go(0, 2'h2, HCR_E, 64'h0, 64'h1234, 4'h0, "hcr read");
  endtask
  task automatic t_traps;
    for (int i = 0; i < 9; i++) begin
      cfg = TAB[i][10:4];
      go(0, 2'h1, RPR_E, 64'h0, TAB[i][3:0] == 4'h0 ? 64'hFF : 64'h0, TAB[i][3:0],
         "rpr route");
    end
    cfg = 7'h54;
    go(0, 2'h2, RPR_E, 64'h0, 64'h0, 4'h1, "rpr el2");
  endtask
  task automatic t_el2;
    el2_impl = 1'b0;
    go(1, 2'h3, apr(0), 64'h7, 64'h0, 4'h0, "no el2 write");
    go(0, 2'h3, apr(0), 64'h0, 64'h0, 4'h0, "no el2 read");
    el2_impl = 1'b1;
    go(0, 2'h3, apr(0), 64'h0, 64'h0, 4'h0, "write ignored");
    cfg = 7'h44;
    ev(1'b1, 8'h10, 1'b0);
    cfg = 7'h54;
    go(0, 2'h2, apr(0), 64'h0, 64'h0, 4'h0, "inert ack");
    legacy = 1'b1;
    ev(1'b1, 8'h10, 1'b0);
    go(0, 2'h2, apr(0), 64'h0, 64'h0, 4'h0, "legacy ack");
    go(0, 2'h2, G1_E, 64'h0, 64'h0, 4'h1, "group1 access");
    legacy = 1'b0;
  endtask
  task automatic t_reset64;
    ev(1'b1, 8'h10, 1'b0);
    wide = 1'b0;
    do_reset(2);
    go(0, 2'h2, apr(0), 64'h0, 64'h100, 4'h0, "narrow reset");
    wide = 1'b1;
    do_reset(2);
    go(0, 2'h2, apr(0), 64'h0, 64'h0, 4'h0, "wide reset");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // about 150 cycles of traffic; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    do_reset(12);
    t_reset;
    t_narrow;
    t_track;
    t_group1;
    t_write;
    t_traps;
    t_el2;
    t_reset64;
    stop_test;
  end
endmodule
